//--- logic/vep_panel_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Colour switch cycles eight background colours
// - Five selector switches combine into wipe pattern
// - Joystick only for circle, square, diamond, or while inset is on
// - Inset switch cycles quarter, sixteenth, off
// - Lever end-to-end swaps inset and background bus
// - Inset mode inhibits freeze and strobe
// - Replicate switch cycles four, sixteen, single
// - One-way wipe ignores lever direction
// - Reverse wipe swaps picture placement
// - Per-bus master enable gates digital effects
// - Freeze switch toggles hold and live
// - Strobe: five intervals 0.2-1 s, then off
// - Mosaic: four block sizes, then off
// - Mosaic skips left and top edges
// - Bus A paint: 2 to 5 bits
// - Bus B paint: 1 to 4 bits
// - Key polarity inverts superimpose key
// - Superimpose enable; edges left unkeyed
// - Key source: external camera, bus A, B
// - Title colour: background colour or white
// - Caption style cycles six edge treatments
// - Threshold sets key luminance switching level
// - Lever towards B enlarges bus B portion
// - Wipe switch cycles normal, border, soft
module vep_panel_ctrl (
	input wire logic clk,
	input wire logic nrst,
	input wire logic press_colour,
	input wire logic [4:0] pattern_sel,
	input wire logic press_pip,
	input wire logic press_multi,
	input wire logic press_one_way,
	input wire logic press_reverse,
	input wire logic press_wipe_mode,
	input wire logic [7:0] lever,
	input wire logic [7:0] joy_x,
	input wire logic [7:0] joy_y,
	input wire logic press_on_a,
	input wire logic press_freeze_a,
	input wire logic press_strobe_a,
	input wire logic press_mosaic_a,
	input wire logic press_paint_a,
	input wire logic press_on_b,
	input wire logic press_freeze_b,
	input wire logic press_strobe_b,
	input wire logic press_mosaic_b,
	input wire logic press_paint_b,
	input wire logic press_key_polarity,
	input wire logic press_super_on,
	input wire logic press_external_key_camera,
	input wire logic press_key_bus_a,
	input wire logic press_key_bus_b,
	input wire logic press_title_back,
	input wire logic press_title_white,
	input wire logic press_caption,
	input wire logic [7:0] key_threshold,
	input wire logic [7:0] key_luma,
	input wire logic edge_zone,
	output logic [2:0] fill_colour,
	output logic [4:0] wipe_pattern,
	output logic [4:0] pattern_led,
	output logic pos_valid,
	output logic [7:0] pos_x,
	output logic [7:0] pos_y,
	output logic [1:0] pip_size,
	output logic pip_led,
	output logic pip_inset_from_b,
	output logic [1:0] multi_count,
	output logic multi_led,
	output logic one_way,
	output logic reverse,
	output logic [1:0] wipe_style,
	output logic [7:0] wipe_amount_b,
	output logic freeze_a,
	output logic freeze_b,
	output logic [2:0] strobe_step_a,
	output logic [2:0] strobe_step_b,
	output logic [2:0] mosaic_step_a,
	output logic [2:0] mosaic_step_b,
	output logic mosaic_bypass,
	output logic [2:0] paint_bits_a,
	output logic [2:0] paint_bits_b,
	output logic [9:0] effect_led,
	output logic key_invert,
	output logic super_on,
	output logic [1:0] key_source,
	output logic title_white,
	output logic [2:0] title_style,
	output logic key_active
);
	import vep_pkg::*;

	logic pip_active;
	logic lever_at_a;
	logic lever_at_b;
	logic lever_end;
	logic key_raw;
	vep_bus_if bus_a ();
	vep_bus_if bus_b ();

	// Position-capable patterns: circle, square, diamond
	function automatic logic pattern_positionable(input logic [4:0] p);
		pattern_positionable = (p == 5'h0F) || (p == 5'h10) || (p == 5'h1F);
	endfunction

	// Paint bits: step 0 means off, else base plus step minus one
	function automatic logic [2:0] paint_bits(input logic [2:0] step, input logic [2:0] base);
		paint_bits = (step == 3'h0) ? 3'h0 : 3'(base + step - 3'h1);
	endfunction

	// Three-position cycle shared by inset, replicate and wipe style: 0, 1, 2, back to 0
	function automatic logic [1:0] next_of_three(input logic [1:0] cur);
		next_of_three = (cur == 2'h2) ? 2'h0 : 2'(cur + 2'h1);
	endfunction

	assign pip_active = (pip_size != VEP_PIP_OFF);
	assign lever_at_a = (lever == 8'h00);
	assign lever_at_b = (lever == 8'hFF);

	// Per-bus effect controllers
	vep_bus_effect u_bus_a (
		.clk(clk), .nrst(nrst), .bus(bus_a),
		.press_on(press_on_a), .press_freeze(press_freeze_a), .press_strobe(press_strobe_a),
		.press_mosaic(press_mosaic_a), .press_paint(press_paint_a), .inhibit(pip_active)
	);

	vep_bus_effect u_bus_b (
		.clk(clk), .nrst(nrst), .bus(bus_b),
		.press_on(press_on_b), .press_freeze(press_freeze_b), .press_strobe(press_strobe_b),
		.press_mosaic(press_mosaic_b), .press_paint(press_paint_b), .inhibit(pip_active)
	);

	// Background colour advances one step per press, wraps after black
	always_ff @(posedge clk) begin
		if (!nrst)
			fill_colour <= VEP_COL_WHITE;
		else if (press_colour)
			fill_colour <= 3'(fill_colour + 3'h1);
	end

	// Pattern selector state and its LEDs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			wipe_pattern <= VEP_PATTERN_RESET;
			pattern_led <= VEP_PATTERN_RESET;
		end else begin
			wipe_pattern <= pattern_sel;
			pattern_led <= pattern_sel;
		end
	end

	// Joystick position passes only for positionable shapes or inset
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pos_valid <= 1'b0;
			pos_x <= 8'h00;
			pos_y <= 8'h00;
		end else begin
			pos_valid <= pattern_positionable(pattern_sel) || pip_active;
			if (pattern_positionable(pattern_sel) || pip_active) begin
				pos_x <= joy_x;
				pos_y <= joy_y;
			end
		end
	end

	// Inset size cycles quarter, sixteenth, off
	always_ff @(posedge clk) begin
		if (!nrst)
			pip_size <= VEP_PIP_OFF;
		else if (press_pip)
			pip_size <= next_of_three(pip_size);
	end

	// Inset source follows the lever end last reached while inset is active
	always_ff @(posedge clk) begin
		if (!nrst)
			pip_inset_from_b <= 1'b1;
		else if (pip_active && lever_at_a)
			pip_inset_from_b <= 1'b1;
		else if (pip_active && lever_at_b)
			pip_inset_from_b <= 1'b0;
	end

	// Replication cycles four, sixteen, single
	always_ff @(posedge clk) begin
		if (!nrst)
			multi_count <= VEP_MULTI_ONE;
		else if (press_multi)
			multi_count <= next_of_three(multi_count);
	end

	// One-way and reverse wipe toggles
	always_ff @(posedge clk) begin
		if (!nrst) begin
			one_way <= 1'b0;
			reverse <= 1'b0;
		end else begin
			if (press_one_way)
				one_way <= !one_way;
			if (press_reverse)
				reverse <= !reverse;
		end
	end

	// Wipe edge style cycles normal, border, soft
	always_ff @(posedge clk) begin
		if (!nrst)
			wipe_style <= VEP_WIPE_NORMAL;
		else if (press_wipe_mode)
			wipe_style <= next_of_three(wipe_style);
	end

	// Wipe portion from bus B; one-way folds the lever to one direction
	always_ff @(posedge clk) begin
		if (!nrst)
			wipe_amount_b <= 8'h00;
		else if (one_way && lever[7])
			wipe_amount_b <= 8'(~lever);
		else
			wipe_amount_b <= lever;
	end

	// Bus effect outputs gated by each bus master enable
	always_ff @(posedge clk) begin
		if (!nrst) begin
			freeze_a <= 1'b0;
			freeze_b <= 1'b0;
			strobe_step_a <= VEP_STEP_RESET;
			strobe_step_b <= VEP_STEP_RESET;
			mosaic_step_a <= VEP_STEP_RESET;
			mosaic_step_b <= VEP_STEP_RESET;
			paint_bits_a <= VEP_STEP_RESET;
			paint_bits_b <= VEP_STEP_RESET;
		end else begin
			freeze_a <= bus_a.enable && bus_a.freeze;
			freeze_b <= bus_b.enable && bus_b.freeze;
			strobe_step_a <= bus_a.enable ? bus_a.strobe_step : 3'h0;
			strobe_step_b <= bus_b.enable ? bus_b.strobe_step : 3'h0;
			mosaic_step_a <= bus_a.enable ? bus_a.mosaic_step : 3'h0;
			mosaic_step_b <= bus_b.enable ? bus_b.mosaic_step : 3'h0;
			paint_bits_a <= bus_a.enable ? paint_bits(bus_a.paint_step, VEP_PAINT_BASE_A) : 3'h0;
			paint_bits_b <= bus_b.enable ? paint_bits(bus_b.paint_step, VEP_PAINT_BASE_B) : 3'h0;
		end
	end

	// Mosaic left unprocessed in the edge zone
	assign mosaic_bypass = edge_zone;

	// Superimpose controls
	always_ff @(posedge clk) begin
		if (!nrst) begin
			key_invert <= 1'b0;
			super_on <= 1'b0;
			key_source <= VEP_KEY_EXT;
			title_white <= 1'b0;
		end else begin
			if (press_key_polarity)
				key_invert <= !key_invert;
			if (press_super_on)
				super_on <= !super_on;
			if (press_external_key_camera)
				key_source <= VEP_KEY_EXT;
			else if (press_key_bus_a)
				key_source <= VEP_KEY_BUS_A;
			else if (press_key_bus_b)
				key_source <= VEP_KEY_BUS_B;
			if (press_title_white)
				title_white <= 1'b1;
			else if (press_title_back)
				title_white <= 1'b0;
		end
	end

	// Caption style cycles six treatments
	always_ff @(posedge clk) begin
		if (!nrst)
			title_style <= VEP_TTL_NORMAL;
		else if (press_caption)
			title_style <= (title_style == VEP_TTL_DROP_SHADOW) ?
				VEP_TTL_NORMAL : 3'(title_style + 3'h1);
	end

	// Key decision: threshold, polarity, master enable, edge exclusion
	assign key_raw = (key_luma >= key_threshold);
	always_ff @(posedge clk) begin
		if (!nrst)
			key_active <= 1'b0;
		else
			key_active <= super_on && !edge_zone && (key_raw ^ key_invert);
	end

	// Indicator LEDs
	assign pip_led = pip_active;
	assign multi_led = (multi_count != VEP_MULTI_ONE);
	assign lever_end = lever_at_a || lever_at_b;
	assign effect_led = {bus_b.enable, bus_b.freeze, (bus_b.strobe_step != 3'h0),
		(bus_b.mosaic_step != 3'h0), (bus_b.paint_step != 3'h0),
		bus_a.enable, bus_a.freeze, (bus_a.strobe_step != 3'h0),
		(bus_a.mosaic_step != 3'h0), (bus_a.paint_step != 3'h0)};

	a_colour_step: assert property (@(posedge clk) disable iff (!nrst)
		press_colour |=> fill_colour == 3'($past(fill_colour) + 3'h1))
		else $error("colour did not advance");
	a_pip_cycle: assert property (@(posedge clk) disable iff (!nrst)
		(press_pip && pip_size == VEP_PIP_SIXTEENTH) |=> pip_size == VEP_PIP_OFF)
		else $error("inset did not end");
	a_pos_gate: assert property (@(posedge clk) disable iff (!nrst)
		(!pattern_positionable(pattern_sel) && !pip_active) |=> !pos_valid)
		else $error("joystick honoured wrongly");
	a_multi_wrap: assert property (@(posedge clk) disable iff (!nrst)
		(press_multi && multi_count == VEP_MULTI_SIXTEEN) |=> !multi_led)
		else $error("multi did not return");
	a_bus_gate: assert property (@(posedge clk) disable iff (!nrst)
		!bus_a.enable |=> (!freeze_a && strobe_step_a == 3'h0 && paint_bits_a == 3'h0))
		else $error("bus A effect passed disabled");
	a_super_gate: assert property (@(posedge clk) disable iff (!nrst)
		(!super_on || edge_zone) |=> !key_active) else $error("key active while off");
	a_caption_wrap: assert property (@(posedge clk) disable iff (!nrst)
		(press_caption && title_style == VEP_TTL_DROP_SHADOW) |=> title_style == VEP_TTL_NORMAL)
		else $error("caption did not wrap");
	a_one_way_fold: assert property (@(posedge clk) disable iff (!nrst)
		one_way |=> !wipe_amount_b[7]) else $error("one-way reversed");
	a_pip_swap: assert property (@(posedge clk) disable iff (!nrst)
		(pip_active && lever_end) |=> pip_inset_from_b == $past(lever_at_a))
		else $error("inset source not swapped");
endmodule // vep_panel_ctrl
`default_nettype wire

//--- logic/vep_pkg.sv
`default_nettype none
package vep_pkg;
	// Background colour codes, in press order
	typedef enum logic [2:0] {
		VEP_COL_WHITE = 3'h0,
		VEP_COL_YELLOW = 3'h1,
		VEP_COL_CYAN = 3'h2,
		VEP_COL_GREEN = 3'h3,
		VEP_COL_MAGENTA = 3'h4,
		VEP_COL_RED = 3'h5,
		VEP_COL_BLUE = 3'h6,
		VEP_COL_BLACK = 3'h7
	} vep_colour_t;

	// Inset picture size
	typedef enum logic [1:0] {
		VEP_PIP_OFF = 2'h0,
		VEP_PIP_QUARTER = 2'h1,
		VEP_PIP_SIXTEENTH = 2'h2
	} vep_pip_t;

	// Pattern replication count
	typedef enum logic [1:0] {
		VEP_MULTI_ONE = 2'h0,
		VEP_MULTI_FOUR = 2'h1,
		VEP_MULTI_SIXTEEN = 2'h2
	} vep_multi_t;

	// Wipe edge style
	typedef enum logic [1:0] {
		VEP_WIPE_NORMAL = 2'h0,
		VEP_WIPE_BORDER = 2'h1,
		VEP_WIPE_SOFT = 2'h2
	} vep_wipe_t;

	// Title edge treatment
	typedef enum logic [2:0] {
		VEP_TTL_NORMAL = 3'h0,
		VEP_TTL_NARROW_BORDER = 3'h1,
		VEP_TTL_WIDE_BORDER = 3'h2,
		VEP_TTL_NARROW_SHADOW = 3'h3,
		VEP_TTL_WIDE_SHADOW = 3'h4,
		VEP_TTL_DROP_SHADOW = 3'h5
	} vep_title_t;

	// Key source choice
	typedef enum logic [1:0] {
		VEP_KEY_EXT = 2'h0,
		VEP_KEY_BUS_A = 2'h1,
		VEP_KEY_BUS_B = 2'h2
	} vep_key_src_t;

	// Step counts of the per-bus effects (0 means effect off)
	localparam logic [2:0] VEP_STROBE_STEPS = 3'h5;
	localparam logic [2:0] VEP_MOSAIC_STEPS = 3'h4;
	localparam logic [2:0] VEP_PAINT_STEPS = 3'h4;
	// Lowest paint gradation in bits per bus
	localparam logic [2:0] VEP_PAINT_BASE_A = 3'h2;
	localparam logic [2:0] VEP_PAINT_BASE_B = 3'h1;
	// Strobe interval in ms per step, step 1 = 200 ms, step 5 = 1000 ms
	localparam int VEP_STROBE_STEP_MS = 200;
	localparam int VEP_CLK_HZ = 10000000;
	// Edge band left unkeyed or unprocessed, in pixels/lines
	localparam logic [3:0] VEP_EDGE_BAND = 4'h8;
	localparam logic [2:0] VEP_STEP_RESET = 3'h0;
	localparam logic [4:0] VEP_PATTERN_RESET = 5'h00;
endpackage
`default_nettype wire

//--- logic/vep_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Per-bus effect settings passed from a bus controller to the top
interface vep_bus_if;
	logic enable;
	logic freeze;
	logic [2:0] strobe_step;
	logic [2:0] mosaic_step;
	logic [2:0] paint_step;
	modport ctrl (output enable, freeze, strobe_step, mosaic_step, paint_step);
	modport user (input enable, freeze, strobe_step, mosaic_step, paint_step);
endinterface
`default_nettype wire

//--- logic/vep_bus_effect.sv
`timescale 1ns/1ps
`default_nettype none
// Effect state for one bus: master enable, freeze, strobe, mosaic, paint
module vep_bus_effect (
	input wire logic clk,
	input wire logic nrst,
	input wire logic press_on,
	input wire logic press_freeze,
	input wire logic press_strobe,
	input wire logic press_mosaic,
	input wire logic press_paint,
	input wire logic inhibit,
	vep_bus_if.ctrl bus
);
	import vep_pkg::*;

	// Cyclic step counter: 0 off, 1..max active, then back to 0
	function automatic logic [2:0] next_step(input logic [2:0] cur, input logic [2:0] max);
		next_step = (cur >= max) ? 3'h0 : 3'(cur + 3'h1);
	endfunction

	// Master enable toggles on each press
	always_ff @(posedge clk) begin
		if (!nrst)
			bus.enable <= 1'b0;
		else if (press_on)
			bus.enable <= !bus.enable;
	end

	// Freeze toggles, blocked while inset is active
	always_ff @(posedge clk) begin
		if (!nrst)
			bus.freeze <= 1'b0;
		else if (inhibit)
			bus.freeze <= 1'b0;
		else if (press_freeze)
			bus.freeze <= !bus.freeze;
	end

	// Strobe interval steps, blocked while inset is active
	always_ff @(posedge clk) begin
		if (!nrst)
			bus.strobe_step <= VEP_STEP_RESET;
		else if (inhibit)
			bus.strobe_step <= VEP_STEP_RESET;
		else if (press_strobe)
			bus.strobe_step <= next_step(bus.strobe_step, VEP_STROBE_STEPS);
	end

	// Mosaic and paint step counters
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bus.mosaic_step <= VEP_STEP_RESET;
			bus.paint_step <= VEP_STEP_RESET;
		end else begin
			if (press_mosaic)
				bus.mosaic_step <= next_step(bus.mosaic_step, VEP_MOSAIC_STEPS);
			if (press_paint)
				bus.paint_step <= next_step(bus.paint_step, VEP_PAINT_STEPS);
		end
	end

	a_strobe_range: assert property (@(posedge clk) disable iff (!nrst)
		bus.strobe_step <= VEP_STROBE_STEPS) else $error("strobe step out of range");
	a_inset_inhibit: assert property (@(posedge clk) disable iff (!nrst)
		inhibit |=> (!bus.freeze && bus.strobe_step == 3'h0)) else $error("freeze under inset");
	a_freeze_toggle: assert property (@(posedge clk) disable iff (!nrst)
		(press_freeze && !inhibit) |=> (bus.freeze != $past(bus.freeze)))
		else $error("freeze did not toggle");
	a_mosaic_wrap: assert property (@(posedge clk) disable iff (!nrst)
		(press_mosaic && bus.mosaic_step == VEP_MOSAIC_STEPS) |=> bus.mosaic_step == 3'h0)
		else $error("mosaic did not return off");
endmodule // vep_bus_effect
`default_nettype wire

//--- verification/vep_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// Front-panel switch bank: turns held buttons into one-cycle press pulses
module vep_switch_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [23:0] btn_down,
	output logic [23:0] press
);
	logic [23:0] btn_prev;

	// Remember last button levels so a long hold gives only one pulse
	always_ff @(posedge clk) begin
		if (!nrst) begin
			btn_prev <= 24'h000000;
		end else begin
			btn_prev <= btn_down;
		end
	end

	// Pulse on the press edge only, as the upstream debouncer would
	always_ff @(posedge clk) begin
		if (!nrst) begin
			press <= 24'h000000;
		end else begin
			press <= btn_down & ~btn_prev;
		end
	end
endmodule // vep_switch_model
`default_nettype wire

//--- verification/video_effect_panel_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module video_effect_panel_mode_control_test;
	import vep_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [23:0] btn_down = 24'h000000;
	logic [23:0] press;
	logic [4:0] pattern_sel = 5'h00;
	logic [7:0] lever = 8'h00;
	logic [7:0] joy_x = 8'h12;
	logic [7:0] joy_y = 8'h34;
	logic [7:0] key_threshold = 8'h80;
	logic [7:0] key_luma = 8'h00;
	logic edge_zone = 1'b0;
	logic [2:0] fill_colour, strobe_step_a, strobe_step_b, mosaic_step_a, mosaic_step_b;
	logic [2:0] paint_bits_a, paint_bits_b, title_style;
	logic [4:0] wipe_pattern, pattern_led;
	logic [7:0] pos_x, pos_y, wipe_amount_b;
	logic [1:0] pip_size, multi_count, wipe_style, key_source;
	logic [9:0] effect_led;
	logic pos_valid, pip_led, pip_inset_from_b, multi_led, one_way, reverse, freeze_a, freeze_b;
	logic mosaic_bypass, key_invert, super_on, title_white, key_active;
	int bad_count = 0;
	int n_compared = 0;
	int base;
	int e;
	logic [4:0] pats [4] = '{5'h0F, 5'h10, 5'h1F, 5'h03};

	// Clock of 100 ns period
	always #50 clk = ~clk;

	vep_switch_model panel (.clk, .nrst, .btn_down, .press);

	vep_panel_ctrl DUT (
		.clk, .nrst, .press_colour(press[0]), .pattern_sel, .press_pip(press[1]),
		.press_multi(press[2]), .press_one_way(press[3]), .press_reverse(press[4]),
		.press_wipe_mode(press[5]), .lever, .joy_x, .joy_y,
		.press_on_a(press[6]), .press_freeze_a(press[7]), .press_strobe_a(press[8]),
		.press_mosaic_a(press[9]), .press_paint_a(press[10]),
		.press_on_b(press[11]), .press_freeze_b(press[12]), .press_strobe_b(press[13]),
		.press_mosaic_b(press[14]), .press_paint_b(press[15]),
		.press_key_polarity(press[16]), .press_super_on(press[17]),
		.press_external_key_camera(press[18]), .press_key_bus_a(press[19]),
		.press_key_bus_b(press[20]), .press_title_back(press[21]),
		.press_title_white(press[22]), .press_caption(press[23]),
		.key_threshold, .key_luma, .edge_zone, .fill_colour, .wipe_pattern, .pattern_led,
		.pos_valid, .pos_x, .pos_y, .pip_size, .pip_led, .pip_inset_from_b, .multi_count,
		.multi_led, .one_way, .reverse, .wipe_style, .wipe_amount_b, .freeze_a, .freeze_b,
		.strobe_step_a, .strobe_step_b, .mosaic_step_a, .mosaic_step_b, .mosaic_bypass,
		.paint_bits_a, .paint_bits_b, .effect_led, .key_invert, .super_on, .key_source,
		.title_white, .title_style, .key_active
	);

	// Verdict and end of run
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Advance n cycles, landing just after the rising edge
	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk);
			#10;
		end
	endtask

	// One switch press: hold two cycles, release, let results settle
	task automatic push(input int idx);
		btn_down[idx] = 1'b1;
		step(2);
		btn_down[idx] = 1'b0;
		step(3);
	endtask

	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Per-bus gated effect outputs packed as freeze, strobe, mosaic, paint
	function automatic logic [9:0] bus_out(input int b);
		if (b == 1) begin
			return {freeze_b, strobe_step_b, mosaic_step_b, paint_bits_b};
		end
		return {freeze_a, strobe_step_a, mosaic_step_a, paint_bits_a};
	endfunction

	// Watchdog against a hung run
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		$display("[FAIL] watchdog expected end seen hang");
		close_out();
	end

	// Main sequence
	initial begin
		step(4);
		nrst = 1'b1;
		step(1);
		chk("fill reset", 10'h000, 10'(fill_colour));
		chk("inset bus reset", 10'h001, 10'(pip_inset_from_b));
		chk("led reset", 10'h000, effect_led);
		$display("test reset done");

		for (int i = 1; i <= 8; i++) begin
			push(0);
			chk("fill colour", 10'(i % 8), 10'(fill_colour));
		end
		$display("test colour done");

		for (int i = 0; i < 4; i++) begin
			pattern_sel = pats[i];
			joy_x = 8'(8'h20 + i);
			step(3);
			chk("wipe pattern", 10'(pats[i]), 10'(wipe_pattern));
			chk("pattern led", 10'(pats[i]), 10'(pattern_led));
			chk("pos valid", 10'(i < 3), 10'(pos_valid));
			chk("pos x", 10'h022 - 10'(i < 3 ? 2 - i : 0), 10'(pos_x));
			chk("pos y", 10'h034, 10'(pos_y));
		end
		$display("test pattern done");

		for (int b = 0; b < 2; b++) begin
			base = 6 + 5 * b;
			push(base);
			chk("enable led", 10'h001, 10'(effect_led[4 + 5 * b]));
			push(base + 1);
			chk("freeze on", 10'h200, bus_out(b));
			push(base + 1);
			chk("freeze off", 10'h000, bus_out(b));
			for (int i = 1; i <= 6; i++) begin
				push(base + 2);
				chk("strobe step", 10'((i % 6) << 6), bus_out(b));
			end
			for (int i = 1; i <= 5; i++) begin
				push(base + 3);
				chk("mosaic step", 10'((i % 5) << 3), bus_out(b));
			end
			for (int i = 1; i <= 5; i++) begin
				push(base + 4);
				e = (i == 5) ? 0 : i + ((b == 0) ? 1 : 0);
				chk("paint bits", 10'(e), bus_out(b));
			end
			push(base + 1);
			push(base + 2);
			push(base);
			chk("gated off", 10'h000, bus_out(b));
			chk("led keeps state", 10'h00C, (effect_led >> (5 * b)) & 10'h01F);
			push(base);
			chk("gated on", 10'h240, bus_out(b));
			push(base + 1);
			repeat (5) push(base + 2);
		end
		$display("test bus effects done");

		push(1);
		chk("inset quarter", 10'h001, 10'(pip_size));
		chk("inset led", 10'h001, 10'(pip_led));
		chk("inset position", 10'h123, 10'({pos_valid, pos_x}));
		push(7);
		push(8);
		chk("freeze inhibited", 10'h000, bus_out(0));
		lever = 8'hFF;
		step(3);
		chk("inset swap", 10'h000, 10'(pip_inset_from_b));
		lever = 8'h00;
		step(3);
		chk("inset swap back", 10'h001, 10'(pip_inset_from_b));
		push(1);
		chk("inset sixteenth", 10'h002, 10'(pip_size));
		push(1);
		chk("inset off", 10'h000, 10'({pip_size, pip_led}));
		push(7);
		chk("freeze after inset", 10'h200, bus_out(0));
		push(7);
		$display("test inset done");

		for (int i = 1; i <= 3; i++) begin
			push(2);
			chk("multi count", 10'(i % 3), 10'(multi_count));
			chk("multi led", 10'(i % 3 != 0), 10'(multi_led));
			push(5);
			chk("wipe style", 10'(i % 3), 10'(wipe_style));
		end
		lever = 8'h40;
		step(3);
		chk("wipe amount low", 10'h040, 10'(wipe_amount_b));
		lever = 8'hC0;
		step(3);
		chk("wipe amount high", 10'h0C0, 10'(wipe_amount_b));
		push(3);
		chk("one way folded", 10'h13F, 10'({one_way, wipe_amount_b}));
		push(4);
		chk("reverse on", 10'h001, 10'(reverse));
		push(3);
		chk("one way off", 10'h0C0, 10'({one_way, wipe_amount_b}));
		lever = 8'h00;
		$display("test wipe done");

		edge_zone = 1'b1;
		step(2);
		chk("mosaic edge bypass", 10'h001, 10'(mosaic_bypass));
		edge_zone = 1'b0;
		push(17);
		key_luma = 8'h90;
		step(3);
		chk("key above level", 10'h001, 10'({super_on, key_active}) - 10'h002);
		key_luma = 8'h70;
		step(3);
		chk("key below level", 10'h000, 10'(key_active));
		key_luma = 8'h90;
		edge_zone = 1'b1;
		step(3);
		chk("key edge band", 10'h000, 10'(key_active));
		edge_zone = 1'b0;
		push(16);
		chk("key inverted", 10'h002, 10'({key_invert, key_active}));
		push(16);
		push(17);
		chk("super off", 10'h000, 10'({super_on, key_active}));
		for (int i = 0; i < 3; i++) begin
			push(18 + i);
			chk("key source", 10'(i), 10'(key_source));
		end
		push(22);
		chk("title white", 10'h001, 10'(title_white));
		push(21);
		chk("title back", 10'h000, 10'(title_white));
		for (int i = 1; i <= 6; i++) begin
			push(23);
			chk("title style", 10'(i % 6), 10'(title_style));
		end
		$display("test superimpose done");
		close_out();
	end
endmodule // video_effect_panel_mode_control_test
`default_nettype wire
